// ==== inc/bcdau_pkg.sv ====
// Constants, types and the register map of the decimal and binary add unit.
package bcdau_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [31:0] OFS_OPWORD = 32'h0000_0000;
    localparam logic [31:0] OFS_CCR = 32'h0000_0004;
    localparam logic [31:0] OFS_STATUS = 32'h0000_0008;
    localparam logic [31:0] OFS_REGSEL = 32'h0000_000C;
    localparam logic [31:0] OFS_REGDATA = 32'h0000_0010;

    // Opcode recognition fields.
    localparam logic [3:0] NIB_DEC = 4'hC;
    localparam logic [3:0] NIB_ADD = 4'hD;
    localparam logic [4:0] DEC_MID = 5'h10;

    // Operand sizes, shared by the add mode field and the memory port.
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] SZ_BAD = 2'h3;
    localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
    localparam logic [31:0] STEP_WORD = 32'h0000_0002;
    localparam logic [31:0] STEP_LONG = 32'h0000_0004;

    // Effective address modes and the register codes under mode 7.
    localparam logic [2:0] EA_DREG = 3'h0;
    localparam logic [2:0] EA_AREG = 3'h1;
    localparam logic [2:0] EA_IND = 3'h2;
    localparam logic [2:0] EA_POSTINC = 3'h3;
    localparam logic [2:0] EA_PREDEC = 3'h4;
    localparam logic [2:0] EA_EXT = 3'h7;
    localparam logic [2:0] EXT_ABSW = 3'h0;
    localparam logic [2:0] EXT_ABSL = 3'h1;
    localparam logic [2:0] EXT_IMM = 3'h4;

    // Condition code and status bit positions, and the condition code reset value.
    localparam int unsigned FLG_C = 0;
    localparam int unsigned FLG_V = 1;
    localparam int unsigned FLG_Z = 2;
    localparam int unsigned FLG_N = 3;
    localparam int unsigned FLG_X = 4;
    localparam logic [4:0] CCR_RESET = 5'h00;
    localparam int unsigned STAT_BUSY = 0;
    localparam int unsigned STAT_ILLEGAL = 1;

    // Decimal digit correction.
    localparam logic [4:0] BCD_DIGIT_MAX = 5'h09;
    localparam logic [4:0] BCD_ADJUST = 5'h06;

    // Sequencer states, one-hot.
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_DECODE = 7'h02,
        ST_FETCH = 7'h04,
        ST_OPER = 7'h08,
        ST_RDSRC = 7'h10,
        ST_RDDST = 7'h20,
        ST_WRITE = 7'h40
    } bcdau_fsm_t;

    // Request to the operand memory path.
    typedef struct packed {
        logic req;
        logic we;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bcdau_mem_req_t;

    // Entire state of the unit.
    typedef struct packed {
        bcdau_fsm_t st;
        logic [15:0] op;
        logic [15:0][31:0] regs;
        logic [4:0] ccr;
        logic illegal;
        logic [1:0] extCnt;
        logic [31:0] ext;
        logic [31:0] src;
        logic [31:0] eaAddr;
        logic [3:0] regSel;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic extReq;
        bcdau_mem_req_t mem;
    } bcdau_state_t;

endpackage : bcdau_pkg

// ==== verilog/bcdau_core.sv ====
// Decimal add with extend and binary add execution slice with an APB register port.
`timescale 1ns/100ps
`default_nettype none

module bcdau_core
    import bcdau_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB register port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Operand memory path.
    output bcdau_mem_req_t memOut,
    input wire logic memAck,
    input wire logic [31:0] memRdata,
    // Instruction stream for extension words.
    output logic extReq,
    input wire logic extAck,
    input wire logic [15:0] extData
);

    bcdau_state_t s_q;
    bcdau_state_t s_d;

    // Address step of one operand of the given size.
    function automatic logic [31:0] stepSz(input logic [1:0] sz);
        unique case (sz)
            SZ_BYTE: return STEP_BYTE;
            SZ_WORD: return STEP_WORD;
            default: return STEP_LONG;
        endcase
    endfunction : stepSz

    // Replace only the low part of a register that the size covers.
    function automatic logic [31:0] mergeSz(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [1:0] sz);
        unique case (sz)
            SZ_BYTE: return {old[31:8], nw[7:0]};
            SZ_WORD: return {old[31:16], nw[15:0]};
            default: return nw;
        endcase
    endfunction : mergeSz

    // Binary sum at a size with its five flags above the 32-bit result.
    function automatic logic [36:0] addSz(input logic [31:0] a, input logic [31:0] b,
                                          input logic [1:0] sz);
        logic [8:0] s8;
        logic [16:0] s16;
        logic [32:0] s32;
        logic [4:0] f;
        logic [31:0] r;
        logic sa;
        logic sb;
        logic sr;
        s8 = {1'b0, a[7:0]} + {1'b0, b[7:0]};
        s16 = {1'b0, a[15:0]} + {1'b0, b[15:0]};
        s32 = {1'b0, a} + {1'b0, b};
        f = CCR_RESET;
        unique case (sz)
            SZ_BYTE: begin
                r = {24'h00_0000, s8[7:0]};
                f[FLG_C] = s8[8];
                sa = a[7];
                sb = b[7];
                sr = s8[7];
                f[FLG_Z] = (s8[7:0] == 8'h00);
            end
            SZ_WORD: begin
                r = {16'h0000, s16[15:0]};
                f[FLG_C] = s16[16];
                sa = a[15];
                sb = b[15];
                sr = s16[15];
                f[FLG_Z] = (s16[15:0] == 16'h0000);
            end
            default: begin
                r = s32[31:0];
                f[FLG_C] = s32[32];
                sa = a[31];
                sb = b[31];
                sr = s32[31];
                f[FLG_Z] = (s32[31:0] == 32'h0000_0000);
            end
        endcase
        f[FLG_N] = sr;
        f[FLG_V] = (sa == sb) && (sr != sa);
        f[FLG_X] = f[FLG_C];
        return {f, r};
    endfunction : addSz

    // Packed decimal byte sum with carry in; carry out sits in bit 8.
    function automatic logic [8:0] bcdAdd(input logic [7:0] a, input logic [7:0] b,
                                          input logic x);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, x};
        if (lo > BCD_DIGIT_MAX) begin
            lo = lo + BCD_ADJUST;
        end
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
        if (hi > BCD_DIGIT_MAX) begin
            hi = hi + BCD_ADJUST;
        end
        return {hi[4], hi[3:0], lo[3:0]};
    endfunction : bcdAdd

    // Number of extension words an effective address needs.
    function automatic logic [1:0] extWords(input logic [2:0] md, input logic [2:0] rg,
                                            input logic [1:0] sz);
        if (md != EA_EXT) begin
            return 2'h0;
        end
        unique case (rg)
            EXT_ABSW: return 2'h1;
            EXT_ABSL: return 2'h2;
            EXT_IMM: return (sz == SZ_LONG) ? 2'h2 : 2'h1;
            default: return 2'h0;
        endcase
    endfunction : extWords

    // Refuse binary add encodings that this slice does not execute.
    function automatic logic addIllegal(input logic [15:0] op);
        logic extOk;
        logic dispMd;
        extOk = (op[2:0] == EXT_ABSW) || (op[2:0] == EXT_ABSL);
        dispMd = (op[5:3] > EA_PREDEC) && (op[5:3] != EA_EXT);
        if (op[7:6] == SZ_BAD) begin
            return 1'b1;
        end
        if (op[8]) begin
            return (op[5:3] == EA_DREG) || (op[5:3] == EA_AREG) || dispMd
                || ((op[5:3] == EA_EXT) && !extOk);
        end
        return ((op[5:3] == EA_AREG) && (op[7:6] == SZ_BYTE)) || dispMd
            || ((op[5:3] == EA_EXT) && !extOk && (op[2:0] != EXT_IMM));
    endfunction : addIllegal

    // Next-state logic: sequencer, arithmetic and APB slave in one place.
    always_comb begin
        logic [2:0] rx;
        logic [2:0] ry;
        logic [2:0] eaMode;
        logic [1:0] sz;
        logic [31:0] step;
        logic [31:0] aVal;
        logic [31:0] ea;
        logic [31:0] regSrc;
        logic [36:0] addRes;
        logic [8:0] bcdRes;
        logic isDec;
        logic memOp;
        s_d = s_q;
        rx = s_q.op[11:9];
        ry = s_q.op[2:0];
        eaMode = s_q.op[5:3];
        sz = s_q.op[7:6];
        step = stepSz(sz);
        aVal = s_q.regs[{1'b1, ry}];
        ea = aVal;
        regSrc = s_q.ext;
        addRes = 37'h00_0000_0000;
        bcdRes = 9'h000;
        isDec = (s_q.op[15:12] == NIB_DEC) && (s_q.op[8:4] == DEC_MID);
        memOp = 1'b0;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;

        // Instruction sequencer.
        unique case (s_q.st)
            ST_IDLE: begin
            end
            ST_DECODE: begin
                if (isDec && !s_q.op[3]) begin
                    bcdRes = bcdAdd(s_q.regs[{1'b0, ry}][7:0],
                                    s_q.regs[{1'b0, rx}][7:0], s_q.ccr[FLG_X]);
                    s_d.regs[{1'b0, rx}][7:0] = bcdRes[7:0];
                    s_d.ccr[FLG_C] = bcdRes[8];
                    s_d.ccr[FLG_X] = bcdRes[8];
                    if (bcdRes[7:0] != 8'h00) begin
                        s_d.ccr[FLG_Z] = 1'b0;
                    end
                    s_d.st = ST_IDLE;
                end else if (isDec) begin
                    // Source address register first, down by one byte.
                    ea = aVal - STEP_BYTE;
                    s_d.regs[{1'b1, ry}] = ea;
                    s_d.mem = '{req: 1'b1, we: 1'b0, size: SZ_BYTE, addr: ea, wdata: 32'h0};
                    s_d.st = ST_RDSRC;
                end else if ((s_q.op[15:12] == NIB_ADD) && !addIllegal(s_q.op)) begin
                    s_d.extCnt = extWords(eaMode, ry, sz);
                    s_d.ext = 32'h0000_0000;
                    s_d.extReq = (s_d.extCnt != 2'h0);
                    s_d.st = s_d.extReq ? ST_FETCH : ST_OPER;
                end else begin
                    s_d.illegal = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            ST_FETCH: begin
                // Extension words arrive in order, high word of a long first.
                if (extAck) begin
                    s_d.ext = {s_q.ext[15:0], extData};
                    s_d.extCnt = s_q.extCnt - 2'h1;
                    if (s_q.extCnt == 2'h1) begin
                        s_d.extReq = 1'b0;
                        s_d.st = ST_OPER;
                    end
                end
            end
            ST_OPER: begin
                unique case (eaMode)
                    EA_DREG: regSrc = s_q.regs[{1'b0, ry}];
                    EA_AREG: regSrc = aVal;
                    EA_IND: memOp = 1'b1;
                    EA_POSTINC: begin
                        memOp = 1'b1;
                        s_d.regs[{1'b1, ry}] = aVal + step;
                    end
                    EA_PREDEC: begin
                        memOp = 1'b1;
                        ea = aVal - step;
                        s_d.regs[{1'b1, ry}] = ea;
                    end
                    default: begin
                        memOp = (ry != EXT_IMM);
                        ea = (ry == EXT_ABSW) ? {{16{s_q.ext[15]}}, s_q.ext[15:0]} : s_q.ext;
                    end
                endcase
                if (memOp) begin
                    s_d.eaAddr = ea;
                    s_d.mem = '{req: 1'b1, we: 1'b0, size: sz, addr: ea, wdata: 32'h0};
                    s_d.st = s_q.op[8] ? ST_RDDST : ST_RDSRC;
                end else begin
                    addRes = addSz(regSrc, s_q.regs[{1'b0, rx}], sz);
                    s_d.regs[{1'b0, rx}] = mergeSz(s_q.regs[{1'b0, rx}], addRes[31:0], sz);
                    s_d.ccr = addRes[36:32];
                    s_d.st = ST_IDLE;
                end
            end
            ST_RDSRC: begin
                if (memAck) begin
                    s_d.src = memRdata;
                    s_d.mem.req = 1'b0;
                    if (isDec) begin
                        // Destination register goes down only after the source read.
                        ea = s_q.regs[{1'b1, rx}] - STEP_BYTE;
                        s_d.regs[{1'b1, rx}] = ea;
                        s_d.eaAddr = ea;
                        s_d.mem = '{req: 1'b1, we: 1'b0, size: SZ_BYTE, addr: ea, wdata: 32'h0};
                        s_d.st = ST_RDDST;
                    end else begin
                        addRes = addSz(memRdata, s_q.regs[{1'b0, rx}], sz);
                        s_d.regs[{1'b0, rx}] = mergeSz(s_q.regs[{1'b0, rx}], addRes[31:0], sz);
                        s_d.ccr = addRes[36:32];
                        s_d.st = ST_IDLE;
                    end
                end
            end
            ST_RDDST: begin
                if (memAck) begin
                    if (isDec) begin
                        bcdRes = bcdAdd(s_q.src[7:0], memRdata[7:0], s_q.ccr[FLG_X]);
                        s_d.ccr[FLG_C] = bcdRes[8];
                        s_d.ccr[FLG_X] = bcdRes[8];
                        if (bcdRes[7:0] != 8'h00) begin
                            s_d.ccr[FLG_Z] = 1'b0;
                        end
                        s_d.mem.wdata = {24'h00_0000, bcdRes[7:0]};
                    end else begin
                        addRes = addSz(s_q.regs[{1'b0, rx}], memRdata, sz);
                        s_d.ccr = addRes[36:32];
                        s_d.mem.wdata = addRes[31:0];
                    end
                    s_d.mem.we = 1'b1;
                    s_d.mem.addr = s_q.eaAddr;
                    s_d.st = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (memAck) begin
                    s_d.mem.req = 1'b0;
                    s_d.mem.we = 1'b0;
                    s_d.st = ST_IDLE;
                end
            end
        endcase

        // APB setup cycle: answer is prepared here and shown in the access cycle.
        if (psel && !penable) begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0000_0000;
            unique case (paddr)
                OFS_OPWORD: begin
                    s_d.prdata = {16'h0000, s_q.op};
                    s_d.pslverr = pwrite && (s_q.st != ST_IDLE);
                end
                OFS_CCR: begin
                    s_d.prdata = {27'h000_0000, s_q.ccr};
                    s_d.pslverr = pwrite && (s_q.st != ST_IDLE);
                end
                OFS_STATUS: begin
                    s_d.prdata[STAT_BUSY] = (s_q.st != ST_IDLE);
                    s_d.prdata[STAT_ILLEGAL] = s_q.illegal;
                    s_d.pslverr = pwrite;
                end
                OFS_REGSEL: s_d.prdata = {28'h000_0000, s_q.regSel};
                OFS_REGDATA: begin
                    s_d.prdata = s_q.regs[s_q.regSel];
                    s_d.pslverr = pwrite && (s_q.st != ST_IDLE);
                end
                default: s_d.pslverr = 1'b1;
            endcase
        end

        // APB write lands at the completing edge; the unit is idle here except for REGSEL writes, which are accepted while busy.
        if (psel && penable && s_q.pready && pwrite && !s_q.pslverr) begin
            unique case (paddr)
                OFS_OPWORD: begin
                    s_d.op = pwdata[15:0];
                    s_d.illegal = 1'b0;
                    s_d.st = ST_DECODE;
                end
                OFS_CCR: s_d.ccr = pwdata[4:0];
                OFS_REGSEL: s_d.regSel = pwdata[3:0];
                OFS_REGDATA: s_d.regs[s_q.regSel] = pwdata;
                default: begin
                end
            endcase
        end
    end

    // State register; the register file resets to zero with everything else except st, which loads ST_IDLE.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state register.
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign memOut = s_q.mem;
    assign extReq = s_q.extReq;

endmodule : bcdau_core

`default_nettype wire

// ==== sim/bcdau_core_asserts.sv ====
// Port checker for the add unit, bound to the core.
`timescale 1ns/100ps
`default_nettype none
module bcdau_core_asserts
    import bcdau_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Memory and extension paths.
    input wire bcdau_mem_req_t memOut,
    input wire logic memAck,
    input wire logic extReq,
    input wire logic extAck
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] lastAddr_q;
    logic lastWe_q;
    // Last completed access; reset as a write.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lastAddr_q <= '0;
            lastWe_q <= 1'b1;
        end else if (memOut.req && memAck) begin
            lastAddr_q <= memOut.addr;
            lastWe_q <= memOut.we;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_write_done;
        memOut.req && memAck ##0 memOut.we;
    endsequence
    chk_apb_nowait: assert property (s_setup |=> pready)
        else $error("APB wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready not a pulse");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_mem_hold: assert property (memOut.req && !memAck && !$past(memAck) |=> $stable(memOut))
        else $error("memory request changed early");
    chk_req_drop: assert property ($fell(memOut.req) |-> $past(memAck))
        else $error("memory request dropped early");
    chk_write_after_read: assert property (s_write_done |-> !lastWe_q && memOut.addr == lastAddr_q)
        else $error("write without read of same place");
    chk_ext_hold: assert property (extReq && !extAck |=> extReq)
        else $error("extension request dropped");
    chk_ext_first: assert property (extReq |-> !memOut.req)
        else $error("operand access during extension fetch");
endmodule : bcdau_core_asserts
bind bcdau_core bcdau_core_asserts u_bcdau_core_asserts (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .memOut(memOut),
    .memAck(memAck), .extReq(extReq), .extAck(extAck));
`default_nettype wire

// ==== sim/bcdau_mem_model.sv ====
// Operand memory and instruction stream model.
`timescale 1ns/100ps
`default_nettype none
module bcdau_mem_model
    import bcdau_pkg::*;
(
    // Clock, reset and pacing.
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic slow,
    // Operand memory path.
    input wire bcdau_mem_req_t memIn,
    output logic memAck,
    output logic [31:0] memRdata,
    // Extension word stream.
    input wire logic extReq,
    output logic extAck,
    output logic [15:0] extData
);
    logic [7:0] mem [256];
    logic [15:0] extWords [2];
    int memCnt;
    int extCnt;
    int extIdx;
    // Big-endian read of one, two or four bytes.
    function automatic logic [31:0] rdw(input logic [31:0] a, input logic [1:0] s);
        logic [31:0] v;
        v = '0;
        for (int i = 0; i < (1 << s); i++) v = {v[23:0], mem[8'(a + i)]};
        return v;
    endfunction : rdw
    // Each access is acked at its second requesting edge after the previous ack, at its fourth when slow.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            memAck <= 1'b0;
            memRdata <= '0;
            memCnt = 0;
        end else if (memAck) begin
            if (memIn.we) begin
                for (int i = 0; i < (1 << memIn.size); i++)
                    mem[8'(memIn.addr + i)] = 8'(memIn.wdata >> (8 * ((1 << memIn.size) - 1 - i)));
            end
            memAck <= 1'b0;
            memRdata <= ~memRdata;
            memCnt = 0;
        end else begin
            memRdata <= ~memRdata;
            if (memIn.req) memCnt++;
            if (memCnt > (slow ? 3 : 1)) begin
                memAck <= 1'b1;
                memRdata <= rdw(memIn.addr, memIn.size);
            end
        end
    end
    // Extension words in order; data toggles while idle.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            extAck <= 1'b0;
            extData <= 16'h0000;
            extCnt = 0;
            extIdx = 0;
        end else if (extAck) begin
            extAck <= 1'b0;
            extData <= ~extData;
            extCnt = 0;
            extIdx++;
        end else if (extReq) begin
            extCnt++;
            if (extCnt > (slow ? 3 : 1)) begin
                extAck <= 1'b1;
                extData <= extWords[extIdx % 2];
            end
        end else begin
            extData <= ~extData;
            extCnt = 0;
            extIdx = 0;
        end
    end
endmodule : bcdau_mem_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the add unit.
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import bcdau_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic slow = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    bcdau_mem_req_t memOut;
    logic memAck;
    logic [31:0] memRdata;
    logic extReq;
    logic extAck;
    logic [15:0] extData;
    int num_errors = 0;
    int check_count = 0;

    // Free-running 125 MHz clock.
    always #4 ref_clk = ~ref_clk;

    bcdau_core u_bcdau_core (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .memOut(memOut), .memAck(memAck), .memRdata(memRdata),
        .extReq(extReq), .extAck(extAck), .extData(extData));
    bcdau_mem_model u_bcdau_mem_model (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
        .memIn(memOut), .memAck(memAck), .memRdata(memRdata), .extReq(extReq),
        .extAck(extAck), .extData(extData));

    task automatic stop_test();
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // One APB transfer; pready is seen mid-cycle, the next edge completes it.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            stop_test();
        end
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, '0, r, e);
        check(r, exp, what);
    endtask : rdchk

    task automatic set_reg(input logic [3:0] i, input logic [31:0] v);
        wr(OFS_REGSEL, {28'h0, i});
        wr(OFS_REGDATA, v);
    endtask : set_reg

    task automatic reg_chk(input logic [3:0] i, input logic [31:0] exp, input string what);
        wr(OFS_REGSEL, {28'h0, i});
        rdchk(OFS_REGDATA, exp, what);
    endtask : reg_chk

    // Polls busy under a bound.
    task automatic wait_idle();
        int n;
        logic [31:0] r;
        logic e;
        n = 0;
        do begin
            apb(1'b0, OFS_STATUS, '0, r, e);
            n++;
        end while (r[STAT_BUSY] !== 1'b0 && n < 100);
        if (n >= 100) begin
            num_errors++;
            stop_test();
        end
    endtask : wait_idle

    task automatic run(input logic [15:0] op);
        wr(OFS_OPWORD, {16'h0000, op});
        wait_idle();
    endtask : run

    task automatic sc_reset();
        logic [31:0] r;
        logic e;
        rdchk(OFS_CCR, '0, "flags after reset");
        reg_chk(4'hF, '0, "reg after reset");
        apb(1'b0, 32'h40, '0, r, e);
        check(r, '0, "unmapped read");
        check({31'h0, e}, 32'h1, "unmapped error");
        apb(1'b1, OFS_STATUS, 32'h3, r, e);
        check({31'h0, e}, 32'h1, "status write refused");
    endtask : sc_reset

    // Register decimal add: preserved upper bits, carry out, zero kept and zero cleared.
    task automatic sc_dec_reg();
        logic [31:0] dst [3] = '{32'hAABB_CC45, 32'h50, 32'h99};
        logic [31:0] src [3] = '{32'h38, 32'h50, 32'h0};
        logic [31:0] res [3] = '{32'hAABB_CC84, 32'h0, 32'h0};
        logic [31:0] cin [3] = '{32'h14, 32'h4, 32'h10};
        logic [31:0] cout [3] = '{32'h0, 32'h15, 32'h11};
        for (int k = 0; k < 3; k++) begin
            set_reg(4'h1, dst[k]);
            set_reg(4'h2, src[k]);
            wr(OFS_CCR, cin[k]);
            run(16'hC302);
            reg_chk(4'h1, res[k], "decimal sum");
            rdchk(OFS_CCR, cout[k], "decimal flags");
        end
    endtask : sc_dec_reg

    // Memory decimal add with a slow partner and a refused write while busy.
    task automatic sc_dec_mem();
        logic [31:0] r;
        logic e;
        slow <= 1'b1;
        u_bcdau_mem_model.mem[8'h1F] = 8'h27;
        u_bcdau_mem_model.mem[8'h2F] = 8'h19;
        set_reg(4'h8, 32'h20);
        set_reg(4'h9, 32'h30);
        wr(OFS_CCR, 32'h4);
        wr(OFS_OPWORD, 32'hC308);
        apb(1'b1, OFS_CCR, 32'h1F, r, e);
        check({31'h0, e}, 32'h1, "write while busy");
        wait_idle();
        check({24'h0, u_bcdau_mem_model.mem[8'h2F]}, 32'h46, "memory sum");
        reg_chk(4'h8, 32'h1F, "src pointer");
        reg_chk(4'h9, 32'h2F, "dst pointer");
        rdchk(OFS_CCR, '0, "mem flags");
        slow <= 1'b0;
    endtask : sc_dec_mem

    // Register binary add at all three sizes.
    task automatic sc_add_reg();
        logic [31:0] d3 [3] = '{32'h1234_567F, 32'h1234_FFFF, 32'h4000_0000};
        logic [31:0] d4 [3] = '{32'h1, 32'h1, 32'h4000_0000};
        logic [31:0] res [3] = '{32'h1234_5680, 32'h1234_0000, 32'h8000_0000};
        logic [31:0] cc [3] = '{32'hA, 32'h15, 32'hA};
        for (int k = 0; k < 3; k++) begin
            set_reg(4'h3, d3[k]);
            set_reg(4'h4, d4[k]);
            wr(OFS_CCR, '0);
            run(16'hD604 | 16'(k << 6));
            reg_chk(4'h3, res[k], "binary sum");
            rdchk(OFS_CCR, cc[k], "binary flags");
        end
    endtask : sc_add_reg

    // Binary add into memory by a short absolute address, then refused forms.
    task automatic sc_add_mem();
        slow <= 1'b1;
        u_bcdau_mem_model.mem[8'h40] = 8'h10;
        u_bcdau_mem_model.extWords[0] = 16'h0040;
        set_reg(4'h5, 32'h22);
        set_reg(4'h0, 32'h5A);
        wr(OFS_CCR, 32'h1F);
        run(16'hDB38);
        check({24'h0, u_bcdau_mem_model.mem[8'h40]}, 32'h32, "memory add");
        rdchk(OFS_CCR, '0, "add flags");
        run(16'hDB00);
        rdchk(OFS_STATUS, 32'h2, "bad destination");
        reg_chk(4'h0, 32'h5A, "register kept");
        run(16'hC322);
        rdchk(OFS_STATUS, 32'h2, "bad decimal pattern");
        slow <= 1'b0;
    endtask : sc_add_mem

    // Main sequence.
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        sc_reset();
        sc_dec_reg();
        sc_dec_mem();
        sc_add_reg();
        sc_add_mem();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
